// ### dv/nco_far_side.sv
/*
  Far side of the oscillator block: the clock sources that feed it.
  Assumes: run from the bench's system clock; pin clock on command.
*/
`timescale 1ns/1ns

module nco_far_side (
  input wire logic i_clk_sys,
  output logic o_fast_osc_clk,
  output logic o_logic_cell1_output,
  output logic o_ext_clk_pin
);
  int cnt;

  initial begin
    cnt = 0;
    o_fast_osc_clk = 1'b0;
    o_logic_cell1_output = 1'b0;
    o_ext_clk_pin = 1'b0;
  end

  // =========================================================
  // free-running sources, period 6 and 16 system clocks
  always @(posedge i_clk_sys) begin
    cnt <= cnt + 1;
    if (cnt % 3 == 0) o_fast_osc_clk <= !o_fast_osc_clk;
    if (cnt % 8 == 0) o_logic_cell1_output <= !o_logic_cell1_output;
  end

  // =========================================================
  // pin clock stands still between bursts of n rising edges
  task automatic pin_ticks(input int n);
    repeat (n) begin
      @(posedge i_clk_sys);
      o_ext_clk_pin <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      o_ext_clk_pin <= 1'b0;
      repeat (3) @(posedge i_clk_sys);
    end
  endtask
endmodule

// ### dv/tb.sv
/*
  Self-checking bench of the numerically controlled oscillator.
  Assumes: design, map header and far-side model compiled before it.
*/
`timescale 1ns/1ns
`include "nco_map.svh"

module tb;
  import nco_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  av_req_t av = '0;
  logic [31:0] rdata;
  logic wait_req, osc_out, pin_out, pin_oe_n, irq, keep_alive;
  logic fast_clk, cell_out, pin_clk;
  logic [31:0] q, v;
  int bad_count = 0;
  int samples_checked = 0;
  int acc, stp, ovf, k, w;
  int lo_b[4] = '{6, 45, 2, 5};
  int hi_b[4] = '{11, 60, 5, 5};

  always #5 clk = ~clk;

  numeric_osc_freq_divider u_dut (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_av(av), .o_readdata(rdata),
    .o_waitrequest(wait_req), .i_fast_osc_clk(fast_clk),
    .i_logic_cell1_output(cell_out), .i_ext_clk_pin(pin_clk),
    .o_osc_out(osc_out), .o_pin_out(pin_out), .o_pin_oe_n(pin_oe_n),
    .o_irq(irq), .o_fast_osc_keep_alive(keep_alive)
  );

  nco_far_side u_far (
    .i_clk_sys(clk), .o_fast_osc_clk(fast_clk),
    .o_logic_cell1_output(cell_out), .o_ext_clk_pin(pin_clk)
  );

  // =========================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    av.read <= !wr;
    av.write <= wr;
    av.address <= a;
    av.byteenable <= 4'hf;
    av.writedata <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 100);
    q = rdata;
    av.read <= 1'b0;
    av.write <= 1'b0;
    if (n >= 100) chk("bus_answer", 1, 0);
  endtask

  task automatic rd_acc(output logic [31:0] r);
    r = '0;
    bus(0, `NCO_OFS_ACC_LO, 8'h00);
    r[7:0] = q[7:0];
    bus(0, `NCO_OFS_ACC_HI, 8'h00);
    r[15:8] = q[7:0];
    bus(0, `NCO_OFS_ACC_UP, 8'h00);
    r[19:16] = q[3:0];
  endtask

  task automatic wr_acc(input int a);
    bus(1, `NCO_OFS_ACC_LO, 8'(a));
    bus(1, `NCO_OFS_ACC_HI, 8'(a >> 8));
    bus(1, `NCO_OFS_ACC_UP, 8'(a >> 16));
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      bus(0, 5'(i * 4), 8'h00);
      chk("reset_reg", 32'h0, q);
    end
  endtask

  task automatic complete_run();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    complete_run();
  end

  // =========================================================
  // scenarios
  initial begin
    void'($urandom(55957));
    do_reset();
    bus(1, `NCO_OFS_ACC_UP, 8'hff);
    bus(0, `NCO_OFS_ACC_UP, 8'h00);
    chk("acc_upper", 32'h0f, q);
    bus(1, `NCO_OFS_CTRL, 8'hef);
    bus(0, `NCO_OFS_CTRL, 8'h00);
    chk("ctrl", 32'hc1, q);
    bus(1, `NCO_OFS_CLKSEL, 8'hff);
    bus(0, `NCO_OFS_CLKSEL, 8'h00);
    chk("clksel", 32'he3, q);
    bus(1, 5'h02, 8'h5a);
    bus(0, 5'h02, 8'h00);
    chk("unmapped", 32'h0, q);
    bus(1, `NCO_OFS_STEP_HI, 8'ha5);
    bus(0, `NCO_OFS_STEP_HI, 8'h00);
    chk("step_hi", 32'ha5, q);
    do_reset();
    for (int i = 0; i < 4; i++) begin
      bus(1, `NCO_OFS_CTRL, {2'(i), 6'h00});
      repeat (2) @(posedge clk);
      chk("pin_oe_n", i != 3, pin_oe_n);
      chk("pin_out", 1'b0, pin_out);
    end
    for (int i = 0; i < 16; i++) begin
      bus(1, `NCO_OFS_CTRL, (i >= 8) ? 8'h80 : 8'h00);
      bus(1, `NCO_OFS_IRQ, {4'h0, 3'(i), 1'b1});
      repeat (2) @(posedge clk);
      chk("irq_gate", i == 15, irq);
    end
    // polarity change raises the flag only with irq enable set
    do_reset();
    bus(1, `NCO_OFS_IRQ, 8'h02);
    bus(1, `NCO_OFS_CTRL, 8'h10);
    repeat (2) @(posedge clk);
    chk("pol_out", 1'b1, osc_out);
    bus(0, `NCO_OFS_IRQ, 8'h00);
    chk("pol_flag", 32'h3, q);
    repeat (20) @(posedge clk);
    bus(0, `NCO_OFS_IRQ, 8'h00);
    chk("flag_held", 32'h3, q);
    bus(1, `NCO_OFS_IRQ, 8'h02);
    bus(0, `NCO_OFS_IRQ, 8'h00);
    chk("flag_clear", 32'h2, q);
    bus(1, `NCO_OFS_IRQ, 8'h00);
    bus(1, `NCO_OFS_CTRL, 8'h00);
    bus(0, `NCO_OFS_IRQ, 8'h00);
    chk("no_pol_flag", 32'h0, q);
    // toggle mode against an integer model of the accumulator
    for (int it = 0; it < 4; it++) begin
      do_reset();
      stp = $urandom_range(65535, 1);
      acc = $urandom_range(1048575, 0);
      k = $urandom_range(40, 1);
      bus(1, `NCO_OFS_STEP_HI, 8'(stp >> 8));
      bus(1, `NCO_OFS_STEP_LO, 8'(stp));
      wr_acc(acc);
      bus(1, `NCO_OFS_CLKSEL, 8'h03);
      bus(1, `NCO_OFS_CTRL, {3'b100, 1'(it), 4'h0});
      u_far.pin_ticks(k);
      ovf = (acc + k * stp) >> 20;
      acc = (acc + k * stp) % 1048576;
      w = (ovf % 2) ^ (it % 2);
      rd_acc(v);
      chk("acc", acc, v);
      chk("toggle_out", w, osc_out);
      chk("pin_level", w, pin_out);
      bus(0, `NCO_OFS_CTRL, 8'h00);
      chk("status", 32'h80 | (w << 5) | ((it % 2) << 4), q);
      bus(0, `NCO_OFS_IRQ, 8'h00);
      chk("ovf_flag", ovf > 0, q);
    end
    // enabled step update waits for the second input edge
    do_reset();
    bus(1, `NCO_OFS_STEP_LO, 8'h10);
    bus(1, `NCO_OFS_CLKSEL, 8'h03);
    bus(1, `NCO_OFS_CTRL, 8'h80);
    u_far.pin_ticks(1);
    bus(1, `NCO_OFS_STEP_HI, 8'h00);
    bus(1, `NCO_OFS_STEP_LO, 8'h40);
    u_far.pin_ticks(1);
    rd_acc(v);
    chk("acc_old_step", 32'h20, v);
    u_far.pin_ticks(1);
    rd_acc(v);
    chk("acc_load_edge", 32'h30, v);
    u_far.pin_ticks(1);
    rd_acc(v);
    chk("acc_new_step", 32'h70, v);
    bus(0, `NCO_OFS_STEP_LO, 8'h00);
    chk("step_lo", 32'h40, q);
    // pulse mode, every width code
    for (int c = 0; c < 8; c++) begin
      do_reset();
      bus(1, `NCO_OFS_STEP_HI, 8'h01);
      bus(1, `NCO_OFS_CLKSEL, {3'(c), 5'h03});
      wr_acc(20'hfff00);
      bus(1, `NCO_OFS_CTRL, 8'h81);
      w = 0;
      for (int t = 0; t < 131; t++) begin
        u_far.pin_ticks(1);
        if (t == 0) chk("pulse_late", 1'b0, osc_out);
        w += (osc_out === 1'b1);
      end
      chk("pulse_width", 1 << c, w);
    end
    // every clock source, rate and oscillator keep-alive
    for (int s = 0; s < 4; s++) begin
      do_reset();
      bus(1, `NCO_OFS_STEP_LO, 8'h01);
      bus(1, `NCO_OFS_CLKSEL, 8'(s));
      bus(1, `NCO_OFS_CTRL, 8'h80);
      if (s == 3) u_far.pin_ticks(5);
      else repeat (48) @(posedge clk);
      chk("keep_alive", s == 0, keep_alive);
      bus(1, `NCO_OFS_CTRL, 8'h00);
      rd_acc(v);
      chk("acc_rate", 1, v >= lo_b[s] && v <= hi_b[s]);
    end
    complete_run();
  end
endmodule

// ### logic/nco_map.svh
/*
  Register map, field positions, reset values and codes of the
  numerically controlled oscillator block.
  Assumes: Avalon-MM slave, 32-bit data, one register per aligned word.
*/
`ifndef NCO_MAP_SVH
`define NCO_MAP_SVH

// ==========================================================
// byte addresses
`define NCO_ADDR_W 5
`define NCO_OFS_CTRL 5'h00
`define NCO_OFS_CLKSEL 5'h04
`define NCO_OFS_ACC_LO 5'h08
`define NCO_OFS_ACC_HI 5'h0c
`define NCO_OFS_ACC_UP 5'h10
`define NCO_OFS_STEP_LO 5'h14
`define NCO_OFS_STEP_HI 5'h18
`define NCO_OFS_IRQ 5'h1c

// ==========================================================
// control fields
`define NCO_BIT_EN 7
`define NCO_BIT_OE 6
`define NCO_BIT_OUT 5
`define NCO_BIT_POL 4
`define NCO_BIT_PFM 0
`define NCO_PWS_HI 7
`define NCO_PWS_LO 5
`define NCO_CKS_HI 1
`define NCO_CKS_LO 0
`define NCO_BIT_IF 0
`define NCO_BIT_IE 1
`define NCO_BIT_PERIPH 2
`define NCO_BIT_GLOBAL 3

// ==========================================================
// sizes, codes, reset values
`define NCO_ACC_W 20
`define NCO_STEP_W 16
`define NCO_CKS_FAST 2'h0
`define NCO_CKS_SYS 2'h1
`define NCO_CKS_CELL 2'h2
`define NCO_CKS_PIN 2'h3
`define NCO_RST_BYTE 8'h00
`define NCO_RST_ACC 20'h00000
`define NCO_RST_STEP 16'h0000
`define NCO_PW_ONE 8'h01
`define NCO_RD_ZERO 32'h0000_0000

`endif

// ### logic/nco_pkg.sv
/*
  Types of the numerically controlled oscillator block.
  Assumes: included map header for sizes.
*/
`include "nco_map.svh"

package nco_pkg;

  // ========================================================
  // bus request from the Avalon-MM master
  typedef struct packed {
    logic read;
    logic write;
    logic [`NCO_ADDR_W-1:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } av_req_t;

  // ========================================================
  // step buffer load sequencing
  typedef enum logic [2:0] {
    LD_IDLE = 3'b001,
    LD_EDGE1 = 3'b010,
    LD_EDGE2 = 3'b100
  } load_state_t;

endpackage

// ### logic/numeric_osc_freq_divider.sv
/*
  Numerically controlled oscillator: phase accumulator, double-buffered
  step, toggle or pulse output, polarity, overflow flag.
  Assumes: all inputs synchronous to i_clk_sys; the selected source
  is sampled as a level and its rising edges step the accumulator.
*/
`timescale 1ns/1ns
`include "nco_map.svh"

module numeric_osc_freq_divider (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire nco_pkg::av_req_t i_av,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_fast_osc_clk,
  input wire logic i_logic_cell1_output,
  input wire logic i_ext_clk_pin,
  output logic o_osc_out,
  output logic o_pin_out,
  output logic o_pin_oe_n,
  output logic o_irq,
  output logic o_fast_osc_keep_alive
);
  import nco_pkg::*;

  // ========================================================
  // register state
  logic block_enable_q;
  logic pin_drive_enable_q;
  logic output_polarity_q;
  logic pulse_mode_select_q;
  logic [2:0] pulse_width_code_q;
  logic [1:0] clock_source_code_q;
  logic [`NCO_ACC_W-1:0] phase_accumulator_q;
  logic [7:0] step_low_byte_q;
  logic [7:0] step_high_byte_q;
  logic [`NCO_STEP_W-1:0] step_buf_q;
  logic overflow_irq_flag_q;
  logic overflow_irq_enable_q;
  logic peripheral_irq_enable_q;
  logic global_irq_enable_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic raw_q;
  logic carry_pend_q;
  logic [7:0] pulse_cnt_q;
  logic out_q;
  logic pin_q;
  logic pin_oe_n_q;
  logic irq_q;
  logic keep_q;
  logic [3:0] src_prev_q;
  load_state_t load_q;

  // ========================================================
  // bus decode
  wire logic req = i_av.read | i_av.write;
  // a write lands at the edge where waitrequest is seen low
  wire logic wr_take = i_av.write & ~wait_q & i_av.byteenable[0];
  wire logic [7:0] wbyte = i_av.writedata[7:0];
  wire logic wr_ctrl = wr_take & (i_av.address == `NCO_OFS_CTRL);
  wire logic wr_clk = wr_take & (i_av.address == `NCO_OFS_CLKSEL);
  wire logic wr_acc_lo = wr_take & (i_av.address == `NCO_OFS_ACC_LO);
  wire logic wr_acc_hi = wr_take & (i_av.address == `NCO_OFS_ACC_HI);
  wire logic wr_acc_up = wr_take & (i_av.address == `NCO_OFS_ACC_UP);
  wire logic wr_step_lo = wr_take & (i_av.address == `NCO_OFS_STEP_LO);
  wire logic wr_step_hi = wr_take & (i_av.address == `NCO_OFS_STEP_HI);
  wire logic wr_irq = wr_take & (i_av.address == `NCO_OFS_IRQ);

  // ========================================================
  // input clock selection and edge detect
  logic tick;
  wire logic [3:0] src_now = {i_ext_clk_pin, i_logic_cell1_output,
                              1'b1, i_fast_osc_clk};

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      src_prev_q <= 4'h0;
    end else begin
      src_prev_q <= src_now;
    end
  end

  always_comb begin
    case (clock_source_code_q)
      `NCO_CKS_FAST: tick = src_now[0] & ~src_prev_q[0];
      `NCO_CKS_SYS: tick = 1'b1;
      `NCO_CKS_CELL: tick = src_now[2] & ~src_prev_q[2];
      `NCO_CKS_PIN: tick = src_now[3] & ~src_prev_q[3];
      default: tick = 1'b0;
    endcase
  end

  // the accumulator only advances while the block runs
  wire logic step_edge = tick & block_enable_q;

  // ========================================================
  // adder
  wire logic [`NCO_ACC_W:0] sum = {1'b0, phase_accumulator_q} +
                                  {5'h00, step_buf_q};
  wire logic carry = sum[`NCO_ACC_W];

  // ========================================================
  // bus handshake: one wait cycle, then the answer
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(req & wait_q);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= `NCO_RD_ZERO;
    end else if (i_av.read & wait_q) begin
      rdata_q <= `NCO_RD_ZERO;
      case (i_av.address)
        `NCO_OFS_CTRL: begin
          rdata_q[`NCO_BIT_EN] <= block_enable_q;
          rdata_q[`NCO_BIT_OE] <= pin_drive_enable_q;
          rdata_q[`NCO_BIT_OUT] <= out_q;
          rdata_q[`NCO_BIT_POL] <= output_polarity_q;
          rdata_q[`NCO_BIT_PFM] <= pulse_mode_select_q;
        end
        `NCO_OFS_CLKSEL: begin
          rdata_q[`NCO_PWS_HI:`NCO_PWS_LO] <= pulse_width_code_q;
          rdata_q[`NCO_CKS_HI:`NCO_CKS_LO] <= clock_source_code_q;
        end
        `NCO_OFS_ACC_LO: rdata_q[7:0] <= phase_accumulator_q[7:0];
        `NCO_OFS_ACC_HI: rdata_q[7:0] <= phase_accumulator_q[15:8];
        // top nibble of the upper byte reads zero
        `NCO_OFS_ACC_UP: begin
          rdata_q[3:0] <= phase_accumulator_q[19:16];
        end
        `NCO_OFS_STEP_LO: rdata_q[7:0] <= step_low_byte_q;
        `NCO_OFS_STEP_HI: rdata_q[7:0] <= step_high_byte_q;
        `NCO_OFS_IRQ: begin
          rdata_q[`NCO_BIT_IF] <= overflow_irq_flag_q;
          rdata_q[`NCO_BIT_IE] <= overflow_irq_enable_q;
          rdata_q[`NCO_BIT_PERIPH] <= peripheral_irq_enable_q;
          rdata_q[`NCO_BIT_GLOBAL] <= global_irq_enable_q;
        end
        default: rdata_q <= `NCO_RD_ZERO;
      endcase
    end
  end

  // ========================================================
  // control registers
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      block_enable_q <= 1'b0;
      pin_drive_enable_q <= 1'b0;
      output_polarity_q <= 1'b0;
      pulse_mode_select_q <= 1'b0;
    end else if (wr_ctrl) begin
      block_enable_q <= wbyte[`NCO_BIT_EN];
      pin_drive_enable_q <= wbyte[`NCO_BIT_OE];
      output_polarity_q <= wbyte[`NCO_BIT_POL];
      pulse_mode_select_q <= wbyte[`NCO_BIT_PFM];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pulse_width_code_q <= 3'h0;
      clock_source_code_q <= 2'h0;
    end else if (wr_clk) begin
      pulse_width_code_q <= wbyte[`NCO_PWS_HI:`NCO_PWS_LO];
      clock_source_code_q <= wbyte[`NCO_CKS_HI:`NCO_CKS_LO];
    end
  end

  // ========================================================
  // step registers
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      step_low_byte_q <= `NCO_RST_BYTE;
      step_high_byte_q <= `NCO_RST_BYTE;
    end else begin
      if (wr_step_lo) step_low_byte_q <= wbyte;
      if (wr_step_hi) step_high_byte_q <= wbyte;
    end
  end

  // low-byte write arms a load two input edges later
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      load_q <= LD_IDLE;
    end else if (!block_enable_q) begin
      load_q <= LD_IDLE;
    end else begin
      case (load_q)
        LD_IDLE: if (wr_step_lo) load_q <= LD_EDGE1;
        LD_EDGE1: if (tick) load_q <= LD_EDGE2;
        LD_EDGE2: if (tick) load_q <= LD_IDLE;
        default: load_q <= LD_IDLE;
      endcase
    end
  end

  // hidden buffer; no bus path reads it
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      step_buf_q <= `NCO_RST_STEP;
    end else if (!block_enable_q) begin
      step_buf_q <= {step_high_byte_q, step_low_byte_q};
    end else if (load_q == LD_EDGE2 && tick) begin
      step_buf_q <= {step_high_byte_q, step_low_byte_q};
    end
  end

  // ========================================================
  // accumulator: software write wins over an addition
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_accumulator_q <= `NCO_RST_ACC;
    end else if (wr_acc_lo | wr_acc_hi | wr_acc_up) begin
      if (wr_acc_lo) phase_accumulator_q[7:0] <= wbyte;
      if (wr_acc_hi) phase_accumulator_q[15:8] <= wbyte;
      if (wr_acc_up) phase_accumulator_q[19:16] <= wbyte[3:0];
    end else if (step_edge) begin
      phase_accumulator_q <= sum[`NCO_ACC_W-1:0];
    end
  end

  // ========================================================
  // output shaping
  wire logic [7:0] pulse_len = `NCO_PW_ONE << pulse_width_code_q;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      carry_pend_q <= 1'b0;
    end else if (!block_enable_q) begin
      carry_pend_q <= 1'b0;
    end else if (tick) begin
      carry_pend_q <= carry & pulse_mode_select_q;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      raw_q <= 1'b0;
      pulse_cnt_q <= 8'h00;
    end else if (!block_enable_q) begin
      raw_q <= 1'b0;
      pulse_cnt_q <= 8'h00;
    end else if (tick) begin
      if (!pulse_mode_select_q) begin
        if (carry) begin
          raw_q <= ~raw_q;
        end
      end else if (carry_pend_q) begin
        // width ignored outside pulse mode
        raw_q <= 1'b1;
        pulse_cnt_q <= pulse_len - 8'h01;
      end else if (raw_q) begin
        if (pulse_cnt_q == 8'h00) begin
          raw_q <= 1'b0;
        end else begin
          pulse_cnt_q <= pulse_cnt_q - 8'h01;
        end
      end
    end
  end

  wire logic out_d = raw_q ^ output_polarity_q;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_q <= 1'b0;
      pin_q <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end else begin
      out_q <= out_d;
      pin_q <= out_d;
      pin_oe_n_q <= ~(block_enable_q & pin_drive_enable_q);
    end
  end

  // ========================================================
  // interrupt flag and gating
  wire logic pol_change = wr_ctrl &
    (wbyte[`NCO_BIT_POL] != output_polarity_q);
  wire logic flag_set = (step_edge & carry) |
                        (pol_change & overflow_irq_enable_q);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      overflow_irq_flag_q <= 1'b0;
      overflow_irq_enable_q <= 1'b0;
      peripheral_irq_enable_q <= 1'b0;
      global_irq_enable_q <= 1'b0;
    end else begin
      if (flag_set) begin
        overflow_irq_flag_q <= 1'b1;
      end else if (wr_irq) begin
        overflow_irq_flag_q <= wbyte[`NCO_BIT_IF];
      end
      if (wr_irq) begin
        overflow_irq_enable_q <= wbyte[`NCO_BIT_IE];
        peripheral_irq_enable_q <= wbyte[`NCO_BIT_PERIPH];
        global_irq_enable_q <= wbyte[`NCO_BIT_GLOBAL];
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_q <= 1'b0;
      keep_q <= 1'b0;
    end else begin
      irq_q <= overflow_irq_flag_q & block_enable_q &
               overflow_irq_enable_q & peripheral_irq_enable_q &
               global_irq_enable_q;
      keep_q <= block_enable_q &
                (clock_source_code_q == `NCO_CKS_FAST);
    end
  end

  assign o_readdata = rdata_q;
  assign o_waitrequest = wait_q;
  assign o_osc_out = out_q;
  assign o_pin_out = pin_q;
  assign o_pin_oe_n = pin_oe_n_q;
  assign o_irq = irq_q;
  assign o_fast_osc_keep_alive = keep_q;

  // ========================================================
  // checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  chk_acc_add: assert property (
    step_edge && !(wr_acc_lo || wr_acc_hi || wr_acc_up)
    |=> phase_accumulator_q ==
        $past(phase_accumulator_q) + {4'h0, $past(step_buf_q)})
    else $error("accumulator did not add the step");

  chk_carry_flag: assert property (
    step_edge && carry |=> overflow_irq_flag_q)
    else $error("overflow did not set the flag");

  chk_half_toggle: assert property (
    step_edge && carry && !pulse_mode_select_q && !wr_ctrl
    |=> raw_q != $past(raw_q))
    else $error("toggle mode missed an overflow");

  chk_pulse_start: assert property (
    step_edge && carry_pend_q && pulse_mode_select_q |=> raw_q)
    else $error("pulse did not start after overflow");

  chk_pol_stage: assert property (
    ##1 out_q == ($past(raw_q) ^ $past(output_polarity_q)))
    else $error("polarity stage wrong");

  chk_pin_drive: assert property (
    !block_enable_q |=> o_pin_oe_n)
    else $error("pin driven while block disabled");

  chk_step_idle: assert property (
    !block_enable_q ##1 !block_enable_q
    |-> step_buf_q == $past({step_high_byte_q, step_low_byte_q}))
    else $error("step buffer not loaded while disabled");

  chk_upper_zero: assert property (
    i_av.read && wait_q && i_av.address == `NCO_OFS_ACC_UP
    |=> o_readdata[7:4] == 4'h0)
    else $error("upper accumulator nibble not zero");

  chk_bus_wait: assert property (
    req && wait_q |=> !o_waitrequest ##1 o_waitrequest)
    else $error("waitrequest not a single low cycle");

  chk_irq_gate: assert property (
    o_irq |-> $past(overflow_irq_flag_q && global_irq_enable_q))
    else $error("irq without flag and enables");

  cov_overflow: cover property (step_edge && carry);
  cov_pulse: cover property (pulse_mode_select_q && raw_q ##1 !raw_q);
  cov_armed_load: cover property (load_q == LD_EDGE2 && tick);
  cov_irq: cover property (o_irq);

endmodule
